// File: logic/acr_regs_map.svh
`ifndef ACR_REGS_MAP_SVH
`define ACR_REGS_MAP_SVH

// ----------------------------------------------------------------
// register positions in the cpu register space
// ----------------------------------------------------------------
`define ACR_CTRL_IDX      3'h3
`define ACR_CTRL_ALT      1'b1
`define ACR_XCVR_IDX      3'h2
`define ACR_XCVR_ALT      1'b1
`define ACR_COND_IDX      3'h0
`define ACR_COND_ALT      1'b0

// ----------------------------------------------------------------
// auxiliary control bits
// ----------------------------------------------------------------
`define ACR_TIMER_RUN_BIT 7
`define ACR_TIMER_LD_BIT  6
`define ACR_TIMER_SEL_BIT 5
`define ACR_IRQ_DIR_BIT   4
`define ACR_RSV_BIT       3
`define ACR_CLK_FLT_BIT   2
`define ACR_LOCKOUT_BIT   1
`define ACR_GIE_BIT       0

// ----------------------------------------------------------------
// condition register bits
// ----------------------------------------------------------------
`define ACR_TIMEOUT_BIT   7
`define ACR_RREAD_BIT     6
`define ACR_RWRITE_BIT    5
`define ACR_BIDIR_IRQ_PIN_BIT      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACR_CTRL_RESET    8'h00
`define ACR_XCVR_RESET    8'h00
`define ACR_COND_RESET    8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACR_CLK_PERIOD_NS 25
`define ACR_DIV_SLOW      4'hF
`define ACR_DIV_FAST      4'h1
`define ACR_HOLD_UNIT_NS  500
`define ACR_HOLD_UNIT_CYC (`ACR_HOLD_UNIT_NS / `ACR_CLK_PERIOD_NS)
`define ACR_TSTATES_FAST  3'h3
`define ACR_TSTATES_SLOW  3'h4

`endif

// File: logic/acr_pkg.sv
package acr_pkg;
  typedef logic [7:0]  acr_byte_type;
  typedef logic [15:0] acr_count_type;
  typedef logic [4:0]  acr_irq_type;
endpackage

// File: logic/acr_timer.sv
`timescale 1ns/10ps
`include "acr_regs_map.svh"

module acr_timer (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  run,
  input  wire logic                  load,
  input  wire logic                  clk_sel,
  input  wire acr_pkg::acr_count_type load_value,
  output acr_pkg::acr_count_type     count_r,
  output logic                       zero_pulse_r,
  output logic                       load_done_r
);
  import acr_pkg::*;

  logic [3:0]    div_r;
  logic [3:0]    div_nxt;
  logic [3:0]    div_limit;
  logic          tick;
  acr_count_type count_nxt;

  // ----------------------------------------------------------------
  // prescaler: /16 or /2 enable pulse
  // ----------------------------------------------------------------
  // selecting /2 while running only shortens the current period, no glitch
  assign div_limit = clk_sel ? `ACR_DIV_FAST : `ACR_DIV_SLOW;
  assign tick      = run && (div_r >= div_limit);
  assign div_nxt   = (!run || tick) ? 4'h0 : div_r + 4'h1;

  // load wins, else count down on tick, else hold
  assign count_nxt = load ? load_value : (tick ? count_r - 16'h0001 : count_r);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r        <= 4'h0;
      count_r      <= 16'h0000;
      zero_pulse_r <= 1'b0;
      load_done_r  <= 1'b0;
    end else begin
      div_r        <= div_nxt;
      count_r      <= count_nxt;
      zero_pulse_r <= tick && (count_r == 16'h0001);
      load_done_r  <= load;
    end
  end
endmodule

// File: logic/acr_regs.sv
`timescale 1ns/10ps
`include "acr_regs_map.svh"

// ----------------------------------------------------------------
// Summary of operation
// - run bit high, timer counts down
// - run written zero halts and holds count
// - load bit pulses load, self-clears after
// - clock select: zero /16, one /2
// - direction bit: zero input, one output
// - float bit high floats clock output
// - lockout bit refuses remote grant requests; remote strobes still set the flags
// - global enable gates masked maskable interrupts
// - four-state read bit stretches data reads
// - reserved bit value is never relied on
// - remote read flag set, write-one clears
// - remote write flag set, write-one clears
// - pin status sampled each instruction start
// ----------------------------------------------------------------

module acr_regs (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  cpu_wr,
  input  wire logic                  cpu_alt_bank,
  input  wire logic [2:0]            cpu_reg_num,
  input  wire acr_pkg::acr_byte_type cpu_wr_data,
  output acr_pkg::acr_byte_type      cpu_rd_data_r,
  input  wire acr_pkg::acr_count_type timer_load_value,
  output acr_pkg::acr_count_type     timer_count_r,
  input  wire logic                  instr_start,
  input  wire logic                  bidir_irq_pin_in,
  input  wire logic                  bidir_irq_pin_drive,
  output logic                       bidir_irq_pin_out_r,
  output logic                       bidir_irq_pin_oe_r,
  output logic                       clkout_oe_r,
  input  wire logic                  remote_req,
  output logic                       remote_grant_r,
  input  wire logic                  remote_read_strobe_n,
  input  wire logic                  remote_write_strobe_n,
  input  wire logic                  remote_access_enable,
  input  wire logic                  remote_to_data,
  input  wire acr_pkg::acr_irq_type  irq_raw,
  input  wire acr_pkg::acr_irq_type  irq_mask_sel,
  output acr_pkg::acr_irq_type       irq_enabled_r,
  input  wire logic                  four_tstate_read,
  output logic [2:0]                 read_tstates_r,
  input  wire logic                  protocol_8bit,
  output acr_pkg::acr_byte_type      rx_station_addr_r,
  input  wire logic                  tx_busy,
  output logic                       transmit_active_pin_r
);
  import acr_pkg::*;

  acr_byte_type ctrl_r, ctrl_nxt, xcvr_r, cond_r, cond_nxt;
  logic [2:0]   bidir_irq_pin_s_r, rrd_s_r, rwr_s_r;
  logic         bidir_irq_pin_lvl_r, rrd_lvl_r, rwr_lvl_r, bidir_irq_pin_agree, rrd_agree, rwr_agree;
  logic [9:0]   hold_cnt_r, hold_cnt_nxt;
  logic         tx_busy_d_r;
  logic         zero_pulse, load_done;
  logic         wr_ctrl, wr_xcvr, wr_cond, sel_ctrl, sel_xcvr, sel_cond;
  logic         bidir_irq_pin_level, rrd_trail, rwr_trail, rr_set, rw_set;
  logic         stop_write;
  acr_byte_type rd_mux;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign sel_ctrl = (cpu_alt_bank == `ACR_CTRL_ALT) && (cpu_reg_num == `ACR_CTRL_IDX);
  assign sel_xcvr = (cpu_alt_bank == `ACR_XCVR_ALT) && (cpu_reg_num == `ACR_XCVR_IDX);
  assign sel_cond = (cpu_alt_bank == `ACR_COND_ALT) && (cpu_reg_num == `ACR_COND_IDX);
  assign wr_ctrl  = cpu_wr && sel_ctrl;
  assign wr_xcvr  = cpu_wr && sel_xcvr;
  assign wr_cond  = cpu_wr && sel_cond;
  // reserved bit reads zero, though software may not rely on it
  assign rd_mux   = sel_ctrl ? (ctrl_r & ~(8'h01 << `ACR_RSV_BIT)) :
                    sel_xcvr ? xcvr_r : sel_cond ? cond_r : 8'h00;

  // ----------------------------------------------------------------
  // auxiliary control: load bit self-clears when the timer takes it
  // ----------------------------------------------------------------
  assign stop_write = wr_ctrl && !cpu_wr_data[`ACR_TIMER_RUN_BIT];
  always_comb begin
    ctrl_nxt = wr_ctrl ? cpu_wr_data : ctrl_r;
    if (load_done && !wr_ctrl)
      ctrl_nxt[`ACR_TIMER_LD_BIT] = 1'b0;
    ctrl_nxt[`ACR_RSV_BIT] = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin synchronisers, change counts when stages two and three agree
  // ----------------------------------------------------------------
  // late stages agreeing means the pin held still for two clocks
  function automatic logic stages_agree(logic [2:0] s);
    return s[2] == s[1];
  endfunction

  assign bidir_irq_pin_agree = stages_agree(bidir_irq_pin_s_r);
  assign rrd_agree  = stages_agree(rrd_s_r);
  assign rwr_agree  = stages_agree(rwr_s_r);

  // filtered levels move only on agreement, so a one-clock glitch is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bidir_irq_pin_s_r   <= 3'h0;
      rrd_s_r    <= 3'h7;
      rwr_s_r    <= 3'h7;
      bidir_irq_pin_lvl_r <= 1'b0;
      rrd_lvl_r  <= 1'b1;
      rwr_lvl_r  <= 1'b1;
    end else begin
      bidir_irq_pin_s_r   <= {bidir_irq_pin_s_r[1:0], bidir_irq_pin_in};
      rrd_s_r    <= {rrd_s_r[1:0], remote_read_strobe_n};
      rwr_s_r    <= {rwr_s_r[1:0], remote_write_strobe_n};
      bidir_irq_pin_lvl_r <= bidir_irq_pin_agree ? bidir_irq_pin_s_r[2] : bidir_irq_pin_lvl_r;
      rrd_lvl_r  <= rrd_agree ? rrd_s_r[2] : rrd_lvl_r;
      rwr_lvl_r  <= rwr_agree ? rwr_s_r[2] : rwr_lvl_r;
    end
  end
  assign bidir_irq_pin_level = bidir_irq_pin_lvl_r;
  // trailing edge of an active-low strobe is its filtered rise
  assign rrd_trail  = rrd_agree && rrd_s_r[2] && !rrd_lvl_r;
  assign rwr_trail  = rwr_agree && rwr_s_r[2] && !rwr_lvl_r;
  assign rr_set     = rrd_trail && remote_access_enable && remote_to_data;
  assign rw_set     = rwr_trail && remote_to_data;

  // ----------------------------------------------------------------
  // condition flags: a set in the clearing cycle survives
  // ----------------------------------------------------------------
  always_comb begin
    cond_nxt = cond_r;
    if (wr_cond) begin
      cond_nxt[3:0] = cpu_wr_data[3:0];
      if (cpu_wr_data[`ACR_TIMEOUT_BIT])
        cond_nxt[`ACR_TIMEOUT_BIT] = 1'b0;
      if (cpu_wr_data[`ACR_RREAD_BIT])
        cond_nxt[`ACR_RREAD_BIT] = 1'b0;
      if (cpu_wr_data[`ACR_RWRITE_BIT])
        cond_nxt[`ACR_RWRITE_BIT] = 1'b0;
    end
    if (stop_write)
      cond_nxt[`ACR_TIMEOUT_BIT] = 1'b0;
    if (zero_pulse)
      cond_nxt[`ACR_TIMEOUT_BIT] = 1'b1;
    if (rr_set)
      cond_nxt[`ACR_RREAD_BIT] = 1'b1;
    if (rw_set)
      cond_nxt[`ACR_RWRITE_BIT] = 1'b1;
    if (instr_start)
      cond_nxt[`ACR_BIDIR_IRQ_PIN_BIT] = bidir_irq_pin_level;
  end

  // ----------------------------------------------------------------
  // transmit-active hold: code times 500 ns after the last fill bit
  // ----------------------------------------------------------------
  // only the coax modes carry a hold field; eight-bit modes never hold
  always_comb begin
    hold_cnt_nxt = hold_cnt_r;
    if (tx_busy)
      hold_cnt_nxt = 10'h000;
    else if (tx_busy_d_r && !protocol_8bit)
      hold_cnt_nxt = 10'(xcvr_r[7:3] * `ACR_HOLD_UNIT_CYC);
    else if (hold_cnt_r != 10'h000)
      hold_cnt_nxt = hold_cnt_r - 10'h001;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `ACR_CTRL_RESET;
      xcvr_r <= `ACR_XCVR_RESET;
      cond_r <= `ACR_COND_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      cond_r <= cond_nxt;
      if (wr_xcvr)
        xcvr_r <= cpu_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_rd_data_r         <= 8'h00;
      bidir_irq_pin_out_r            <= 1'b0;
      bidir_irq_pin_oe_r             <= 1'b0;
      clkout_oe_r           <= 1'b1;
      remote_grant_r        <= 1'b0;
      irq_enabled_r         <= 5'h00;
      read_tstates_r        <= `ACR_TSTATES_FAST;
      rx_station_addr_r     <= 8'h00;
      hold_cnt_r            <= 10'h000;
      tx_busy_d_r           <= 1'b0;
      transmit_active_pin_r <= 1'b0;
    end else begin
      cpu_rd_data_r     <= rd_mux;
      bidir_irq_pin_out_r        <= bidir_irq_pin_drive;
      bidir_irq_pin_oe_r         <= ctrl_r[`ACR_IRQ_DIR_BIT];
      clkout_oe_r       <= !ctrl_r[`ACR_CLK_FLT_BIT];
      remote_grant_r    <= remote_req && !ctrl_r[`ACR_LOCKOUT_BIT];
      irq_enabled_r     <= ctrl_r[`ACR_GIE_BIT] ? (irq_raw & irq_mask_sel) : 5'h00;
      read_tstates_r    <= four_tstate_read ? `ACR_TSTATES_SLOW : `ACR_TSTATES_FAST;
      rx_station_addr_r <= protocol_8bit ? xcvr_r : {5'h00, xcvr_r[2:0]};
      hold_cnt_r        <= hold_cnt_nxt;
      tx_busy_d_r       <= tx_busy;
      transmit_active_pin_r <= tx_busy || (hold_cnt_nxt != 10'h000);
    end
  end

  // ----------------------------------------------------------------
  // timer: run, load and clock select straight from the control byte
  // ----------------------------------------------------------------
  acr_timer u_timer (
    .clk          (clk),
    .reset        (reset),
    .run          (ctrl_r[`ACR_TIMER_RUN_BIT]),
    .load         (ctrl_r[`ACR_TIMER_LD_BIT]),
    .clk_sel      (ctrl_r[`ACR_TIMER_SEL_BIT]),
    .load_value   (timer_load_value),
    .count_r      (timer_count_r),
    .zero_pulse_r (zero_pulse),
    .load_done_r  (load_done)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_timer_counts: assert property (ctrl_r[7] && !ctrl_r[6] && ctrl_r[5] |-> ##[1:3]
    timer_count_r != $past(timer_count_r, 3)) else $error("timer not counting");
  a_timer_halts: assert property (!ctrl_r[7] && !ctrl_r[6] |=> $stable(timer_count_r))
    else $error("stopped timer moved");
  a_load_clears: assert property (ctrl_r[6] && !wr_ctrl ##1 !wr_ctrl |=> !ctrl_r[6])
    else $error("load bit stuck");
  a_irq_dir: assert property (##1 bidir_irq_pin_oe_r == $past(ctrl_r[4]))
    else $error("irq pin direction wrong");
  a_clk_float: assert property (ctrl_r[2] |=> !clkout_oe_r)
    else $error("clock output driven while floated");
  a_lockout_refuse: assert property (ctrl_r[1] |=> !remote_grant_r)
    else $error("remote granted while locked");
  a_gie_block: assert property (!ctrl_r[0] |=> irq_enabled_r == 5'h00)
    else $error("interrupt passed with global enable low");
  a_read_stretch: assert property (four_tstate_read |=> read_tstates_r == 3'h4)
    else $error("data read not four states");
  a_hold_time: assert property ($fell(tx_busy) && !protocol_8bit && xcvr_r[7:3] == 5'h01
    |-> transmit_active_pin_r [*8] ##1 transmit_active_pin_r [*8] ##1
    transmit_active_pin_r [*5] ##1 (!transmit_active_pin_r || tx_busy))
    else $error("transmit active hold wrong");
  a_rread_set: assert property (rr_set |=> cond_r[6])
    else $error("remote read flag not set");
  a_rwrite_set: assert property (rw_set |=> cond_r[5])
    else $error("remote write flag not set");
  a_bidir_irq_pin_sample: assert property (instr_start |=> cond_r[4] == $past(bidir_irq_pin_level))
    else $error("pin status not sampled");
  a_timeout_set: assert property (zero_pulse |=> cond_r[7])
    else $error("timeout flag missed");

  c_timeout: cover property (zero_pulse ##1 cond_r[7]);
  c_remote_read: cover property (rr_set);
  c_hold_done: cover property ($fell(transmit_active_pin_r));
endmodule

// File: verif/acr_remote_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// remote host strobes and irq pin neighbour
// ----------------------------------------------------------------
module acr_remote_model (
  input  wire logic clk,
  input  wire logic host_irq,
  input  wire logic bidir_irq_pin_out_r,
  input  wire logic bidir_irq_pin_oe_r,
  output logic      bidir_irq_pin_in,
  output logic      remote_read_strobe_n,
  output logic      remote_write_strobe_n
);
  // pin level: device wins while it drives, else the host level
  assign bidir_irq_pin_in = bidir_irq_pin_oe_r ? bidir_irq_pin_out_r : host_irq;

  // strobes idle high
  initial begin
    remote_read_strobe_n = 1'b1;
    remote_write_strobe_n = 1'b1;
  end

  // one remote strobe, low for four clocks; the rise is the event
  task automatic pulse(input bit wr);
    @(negedge clk);
    if (wr) remote_write_strobe_n = 1'b0;
    else remote_read_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    remote_read_strobe_n = 1'b1;
    remote_write_strobe_n = 1'b1;
  endtask
endmodule

// File: verif/tb_aux_control_condition_regs.sv
`timescale 1ns/10ps

module tb_aux_control_condition_regs;
  import acr_pkg::*;
  typedef struct {int s; logic [15:0] v; logic [15:0] m;} acr_exp_type;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 0, reset = 1, cpu_wr = 0, cpu_alt_bank = 0, instr_start = 0, bidir_irq_pin_drive = 0;
  logic remote_req = 0, remote_access_enable = 0, remote_to_data = 0, four_tstate_read = 0;
  logic protocol_8bit = 0, tx_busy = 0, host_irq = 0, bidir_irq_pin_in, bidir_irq_pin_out_r, bidir_irq_pin_oe_r;
  logic remote_read_strobe_n, remote_write_strobe_n, clkout_oe_r, remote_grant_r;
  logic transmit_active_pin_r;
  logic [2:0]    cpu_reg_num = 0, read_tstates_r;
  acr_byte_type  cpu_wr_data = 0, cpu_rd_data_r, rx_station_addr_r, r;
  acr_count_type timer_load_value = 0, timer_count_r, c0;
  acr_irq_type   irq_raw = 0, irq_mask_sel = 0, irq_enabled_r;
  acr_exp_type   q[$];
  acr_exp_type   e;
  int            num_errors = 0, tests_run = 0;
  event          chk_ev;

  always #12.5 clk = ~clk;

  acr_regs uut (.clk, .reset, .cpu_wr, .cpu_alt_bank, .cpu_reg_num, .cpu_wr_data,
    .cpu_rd_data_r, .timer_load_value, .timer_count_r, .instr_start, .bidir_irq_pin_in, .bidir_irq_pin_drive,
    .bidir_irq_pin_out_r, .bidir_irq_pin_oe_r, .clkout_oe_r, .remote_req, .remote_grant_r,
    .remote_read_strobe_n, .remote_write_strobe_n, .remote_access_enable, .remote_to_data,
    .irq_raw, .irq_mask_sel, .irq_enabled_r, .four_tstate_read, .read_tstates_r,
    .protocol_8bit, .rx_station_addr_r, .tx_busy, .transmit_active_pin_r);

  acr_remote_model host (.clk, .host_irq, .bidir_irq_pin_out_r, .bidir_irq_pin_oe_r, .bidir_irq_pin_in,
    .remote_read_strobe_n, .remote_write_strobe_n);

  // ----------------------------------------------------------------
  // result monitor: drains every note queued so far
  // ----------------------------------------------------------------
  function automatic logic [15:0] obs(int s);
    case (s)
      0: return {8'h00, cpu_rd_data_r};
      1: return timer_count_r;
      2: return {15'h0000, bidir_irq_pin_oe_r};
      3: return {15'h0000, clkout_oe_r};
      4: return {15'h0000, remote_grant_r};
      5: return {11'h000, irq_enabled_r};
      6: return {13'h0000, read_tstates_r};
      7: return {8'h00, rx_station_addr_r};
      8: return {15'h0000, bidir_irq_pin_out_r};
      default: return 16'h0000;
    endcase
  endfunction

  always @(chk_ev) while (q.size() > 0) begin
    e = q.pop_front();
    tests_run++;
    if ((obs(e.s) & e.m) !== (e.v & e.m)) begin
      num_errors++;
      $display("[ERR] %0t sel %0d got %h want %h", $time, e.s, obs(e.s) & e.m, e.v & e.m);
    end
  end

  // ----------------------------------------------------------------
  // driver tasks, all entered just after a falling edge
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_ok(bit c);
    tests_run++;
    if (!c) begin
      num_errors++;
      $display("[ERR] %0t count or timing out of range", $time);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(bit a, logic [2:0] n, acr_byte_type d);
    @(negedge clk);
    {cpu_alt_bank, cpu_reg_num, cpu_wr_data, cpu_wr} = {a, n, d, 1'b1};
    @(negedge clk);
    cpu_wr = 0;
  endtask
  task automatic expect_v(int s, logic [15:0] v, logic [15:0] m = 16'hFFFF);
    q.push_back('{s, v, m});
    -> chk_ev;
  endtask
  // read data is registered, so let two edges pass
  task automatic rd(bit a, logic [2:0] n, acr_byte_type v, acr_byte_type m = 8'hFF);
    {cpu_alt_bank, cpu_reg_num} = {a, n};
    step(2);
    expect_v(0, {8'h00, v}, {8'h00, m});
  endtask
  task automatic wait_flag(int b);
    int i;
    {cpu_alt_bank, cpu_reg_num} = 4'h0;
    for (i = 0; i < 60 && cpu_rd_data_r[b] !== 1'b1; i++) step(1);
    chk_ok(i < 60);
    if (i == 60) conclude();
  endtask
  task automatic hold(acr_byte_type x, bit p8, int lo, int hi);
    int n;
    protocol_8bit = p8;
    wr(1, 2, x);
    tx_busy = 1;
    step(3);
    tx_busy = 0;
    for (n = 0; n < 100 && transmit_active_pin_r === 1'b1; n++) step(1);
    chk_ok(n >= lo && n <= hi);
  endtask

  // guard against a hang
  initial begin
    #2500000;
    num_errors++;
    $display("[ERR] %0t run did not finish", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    r = 8'($urandom(32'hE8445920));
    repeat (10) @(posedge clk);
    @(negedge clk) reset = 0;
    rd(1, 3, 8'h00, 8'hF7);
    rd(1, 2, 8'h00);
    rd(0, 0, 8'h00);
    rd(0, 5, 8'h00);
    expect_v(3, 1);
    expect_v(6, 3);
    r = 8'($urandom);
    wr(1, 2, r);
    rd(1, 2, r);
    protocol_8bit = 1;
    step(2);
    expect_v(7, r);
    protocol_8bit = 0;
    step(2);
    expect_v(7, r[2:0]);
    {irq_raw, irq_mask_sel} = 10'($urandom);
    {remote_req, four_tstate_read, bidir_irq_pin_drive} = 3'b111;
    wr(1, 3, 8'h17);
    rd(1, 3, 8'h17, 8'hF7);
    expect_v(2, 1);
    expect_v(8, 1);
    expect_v(3, 0);
    expect_v(4, 0);
    expect_v(5, irq_raw & irq_mask_sel);
    expect_v(6, 4);
    four_tstate_read = 0;
    wr(1, 3, 8'h00);
    step(2);
    expect_v(2, 0);
    expect_v(3, 1);
    expect_v(4, 1);
    expect_v(5, 0);
    expect_v(6, 3);
    // pin status only moves at an instruction start
    host_irq = 1;
    step(4);
    instr_start = 1;
    step(1);
    {instr_start, host_irq} = 2'b00;
    wr(0, 0, 8'h0A);
    rd(0, 0, 8'h1A, 8'h1F);
    timer_load_value = 16'h0100;
    wr(1, 3, 8'h40);
    step(40);
    expect_v(1, 16'h0100);
    rd(1, 3, 8'h00, 8'hC0);
    wr(1, 3, 8'hC0);
    step(4);
    c0 = timer_count_r;
    step(160);
    chk_ok(16'(c0 - timer_count_r) inside {[9:11]});
    wr(1, 3, 8'h00);
    wr(1, 3, 8'hA0);
    step(2);
    c0 = timer_count_r;
    step(20);
    chk_ok(16'(c0 - timer_count_r) inside {[9:11]});
    wr(1, 3, 8'h20);
    step(40);
    chk_ok(16'(c0 - timer_count_r) inside {[9:13]});
    timer_load_value = 16'h0004;
    wr(1, 3, 8'hE0);
    wait_flag(7);
    wr(1, 3, 8'h20);
    rd(0, 0, 8'h00, 8'h80);
    wr(1, 3, 8'hE0);
    wait_flag(7);
    wr(0, 0, 8'h80);
    rd(0, 0, 8'h00, 8'h80);
    wr(1, 3, 8'h20);
    {remote_access_enable, remote_to_data} = 2'b11;
    host.pulse(0);
    wait_flag(6);
    wr(0, 0, 8'h40);
    rd(0, 0, 8'h00, 8'h40);
    host.pulse(1);
    wait_flag(5);
    wr(0, 0, 8'h20);
    rd(0, 0, 8'h00, 8'h20);
    remote_access_enable = 0;
    host.pulse(0);
    step(10);
    rd(0, 0, 8'h00, 8'h40);
    hold(8'h10, 0, 38, 43);
    hold(8'h08, 0, 19, 23);
    hold(8'h00, 0, 0, 2);
    hold(8'h10, 1, 0, 2);
    conclude();
  end
endmodule
